// ---- tcpv_pkg.sv ----
// Shared constants and carriers for the trap-on-condition and pointer-validate decoder.
// Assumes the main processor delivers both instruction words of an instruction together.
package tcpv_pkg;

  // Primary operation word layout
  localparam logic [15:0] TRAP_OP_MASK = 16'hFFF8;
  localparam logic [15:0] TRAP_OP_MATCH = 16'hF078;
  localparam logic [15:0] GEN_OP_MASK = 16'hFFC0;
  localparam logic [15:0] GEN_OP_MATCH = 16'hF000;
  localparam int OPMODE_LSB = 0;
  localparam int EA_REG_LSB = 0;
  localparam int EA_MODE_LSB = 3;

  // Operation-mode encodings of the conditional trap
  localparam logic [2:0] OPMODE_ONE_WORD = 3'h2;
  localparam logic [2:0] OPMODE_TWO_WORDS = 3'h3;
  localparam logic [2:0] OPMODE_NO_WORDS = 3'h4;

  // Condition word: upper ten bits zero, low six bits condition
  localparam logic [15:0] COND_WORD_MASK = 16'hFFC0;
  localparam logic [5:0] COND_LAST = 6'h0F;
  localparam int COND_SENSE_BIT = 0;
  localparam int COND_SEL_LSB = 1;

  // Validate extension words
  localparam logic [15:0] VAL_FMT1_WORD = 16'h2800;
  localparam logic [15:0] VAL_FMT2_MASK = 16'hFFF8;
  localparam logic [15:0] VAL_FMT2_MATCH = 16'h2C00;
  localparam int VAL_AREG_LSB = 0;

  // Control-alterable addressing modes
  localparam logic [2:0] EA_MODE_IND = 3'h2;
  localparam logic [2:0] EA_MODE_DISP = 3'h5;
  localparam logic [2:0] EA_MODE_INDEX = 3'h6;
  localparam logic [2:0] EA_MODE_OTHER = 3'h7;
  localparam logic [2:0] EA_REG_ABS_W = 3'h0;
  localparam logic [2:0] EA_REG_ABS_L = 3'h1;

  // Instruction lengths in words: base without trailing operands, then trailing operand counts
  localparam logic [2:0] LEN_BASE = 3'h2;
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] LEN_TWO = 3'h2;

  // Access-level compare: top bits of a 32-bit level or address
  localparam int AL_MAX_BITS = 4;
  localparam int ADDR_W = 32;
  localparam logic [31:0] VAL_RESET = 32'h0000_0000;

  // Directive to the main processor
  typedef enum logic [2:0] {
    DIR_CONTINUE,
    DIR_COND_TRAP,
    DIR_PRIVILEGE,
    DIR_LINE_F,
    DIR_ACCESS_LEVEL
  } directive_e;

  // Translation status flags in condition-select order
  typedef struct packed {
    logic c;
    logic g;
    logic i;
    logic w;
    logic a;
    logic s;
    logic l;
    logic b;
  } status_s;
  localparam status_s STATUS_RESET = 8'h00;

  // Instruction as handed over by the processor
  typedef struct packed {
    logic [15:0] op_word;
    logic [15:0] ext_word;
    logic [31:0] ea_addr;
    logic [31:0] areg_value;
  } command_s;

  // Answer to the processor
  typedef struct packed {
    directive_e directive;
    logic [2:0] length_words;
  } response_s;
  localparam response_s RESPONSE_RESET = {DIR_CONTINUE, 3'h0};

  // Result of a finished translation search
  typedef struct packed {
    logic no_valid_translation;
    logic fetch_bus_error;
    logic cache_only_test;
    logic cache_entry_bus_error;
    logic limit_exceeded;
    logic supervisor_fault;
    logic access_denied;
    logic write_protected;
    logic modified_page;
    logic global_shared;
  } search_s;

endpackage

// ---- trap_condition_pointer_validate.sv ----
// Decoder and evaluator for the trap-on-condition and pointer-validate instructions.
// Assumes one command pulse per instruction; the processor acts on each directive it gets back.
`timescale 1ns/1ps

// How it works
// RULE1 - Trap instruction outside supervisor state answers privilege violation, condition ignored.
// RULE2 - True condition answers with the coprocessor conditional-trap vector directive.
// RULE3 - Processor stacks address of next instruction on a taken trap.
// RULE4 - False condition answers continue, nothing else happens.
// RULE5 - Condition bits 3..1 pick one of eight flags; bit 0 inverts test.
// RULE6 - Operation mode 010 one word, 011 two words, 100 no trailing words.
// RULE7 - Trailing operand words are not looked at but counted in length.
// RULE8 - Condition field evaluated here; directive returned to processor.
// RULE9 - Validate compares top source level bits with top address bits, width from count field.
// RULE10 - Source bits greater raises access-level exception, else continue.
// RULE11 - Enable field zero makes validate always raise access-level exception; the code answers line-F first when the effective address mode is illegal.
// RULE12 - Format one takes source level from own validation level register.
// RULE13 - Format two takes source from processor address register chosen by low bits.
// RULE14 - Only control-alterable effective address modes accepted, others illegal.
// RULE15 - Processor hands over the address being validated, not its location.
// RULE16 - Invalid-translation flag set when no valid translation, cleared otherwise.
// RULE17 - Bus-error flag set on descriptor fetch error or errored cache-only hit.
// RULE18 - Neither instruction changes the translation status register.
// RULE19 - Illegal trap operation mode answers line-F exception directive.
module trap_condition_pointer_validate
  import tcpv_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire command_s cmd,
  input wire logic supervisor,
  input wire logic access_enable_field,
  input wire logic [1:0] access_level_count_field,
  input wire logic val_write,
  input wire logic [31:0] val_write_data,
  input wire logic search_done,
  input wire search_s search_result,
  output logic resp_valid,
  output response_s resp,
  output status_s translation_status_reg,
  output logic [31:0] validation_level_reg,
  output logic [2:0] areg_select
);

  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rst_n_int;
  logic is_trap;
  logic is_generic;
  logic val_fmt1;
  logic val_fmt2;
  logic [2:0] operation_mode_field;
  logic [2:0] ea_mode;
  logic [2:0] ea_reg;
  logic [5:0] cond_code;
  logic cond_true;
  logic [2:0] trail_words;
  logic opmode_legal;
  logic [31:0] source_level;
  logic level_too_low;
  response_s resp_next;
  logic [2:0] areg_next;

  // Reset release through two flops so deassertion is clean to the clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rst_n_int = rst_sync2_reg;

  // Condition test: pick a flag, bit 0 flips the sense
  function automatic logic eval_cond(input status_s flags, input logic [5:0] code);
    logic [7:0] vec;
    logic flag;
    vec = flags;
    flag = vec[code[COND_SEL_LSB +: 3]]; // [RULE5]
    eval_cond = code[COND_SENSE_BIT] ? !flag : flag; // [RULE5]
  endfunction

  // Control-alterable modes only; register field matters only for mode 111
  function automatic logic ea_legal(input logic [2:0] mode, input logic [2:0] regn);
    ea_legal = (mode == EA_MODE_IND) || (mode == EA_MODE_DISP) || (mode == EA_MODE_INDEX) ||
               ((mode == EA_MODE_OTHER) && ((regn == EA_REG_ABS_W) || (regn == EA_REG_ABS_L)));
  endfunction

  // Top bits of a level, masked down to the configured compare width
  function automatic logic [AL_MAX_BITS-1:0] top_bits(input logic [31:0] word, input logic [1:0] count);
    logic [AL_MAX_BITS-1:0] mask;
    mask = {AL_MAX_BITS{1'b1}} << (2'd3 - count);
    top_bits = word[ADDR_W-1 -: AL_MAX_BITS] & mask; // [RULE9]
  endfunction

  // Field extraction from the two instruction words
  assign is_trap = (cmd.op_word & TRAP_OP_MASK) == TRAP_OP_MATCH;
  assign is_generic = (cmd.op_word & GEN_OP_MASK) == GEN_OP_MATCH;
  assign val_fmt1 = is_generic && (cmd.ext_word == VAL_FMT1_WORD); // [RULE12]
  assign val_fmt2 = is_generic && ((cmd.ext_word & VAL_FMT2_MASK) == VAL_FMT2_MATCH); // [RULE13]
  assign operation_mode_field = cmd.op_word[OPMODE_LSB +: 3];
  assign ea_mode = cmd.op_word[EA_MODE_LSB +: 3];
  assign ea_reg = cmd.op_word[EA_REG_LSB +: 3];
  assign cond_code = cmd.ext_word[5:0];

  // Conditions read the live status register; nothing here writes it
  assign cond_true = eval_cond(translation_status_reg, cond_code); // [RULE8] [RULE18]

  // Trailing operand words are counted, never inspected
  always_comb begin
    trail_words = 3'h0;
    opmode_legal = 1'b1;
    unique case (operation_mode_field)
      OPMODE_ONE_WORD: trail_words = LEN_ONE; // [RULE6] [RULE7]
      OPMODE_TWO_WORDS: trail_words = LEN_TWO; // [RULE6] [RULE7]
      OPMODE_NO_WORDS: trail_words = 3'h0; // [RULE6]
      default: opmode_legal = 1'b0; // [RULE19]
    endcase
  end

  // Source level: own register in format one, processor register in format two
  assign source_level = val_fmt2 ? cmd.areg_value : validation_level_reg; // [RULE12] [RULE13]
  // Address is taken as the value to check, the processor resolves indirection
  assign level_too_low = top_bits(source_level, access_level_count_field) >
                         top_bits(cmd.ea_addr, access_level_count_field); // [RULE10] [RULE15]

  // Directive selection; privilege first so user code learns nothing of the flags
  always_comb begin
    resp_next = RESPONSE_RESET;
    areg_next = 3'h0;
    if (is_trap) begin
      resp_next.length_words = LEN_BASE + trail_words; // [RULE7]
      if (!supervisor) begin
        resp_next.directive = DIR_PRIVILEGE; // [RULE1]
      end else if (!opmode_legal) begin
        resp_next.directive = DIR_LINE_F; // [RULE19]
        resp_next.length_words = LEN_BASE;
      end else if (((cmd.ext_word & COND_WORD_MASK) != 16'h0000) || (cond_code > COND_LAST)) begin
        resp_next.directive = DIR_LINE_F;
      end else if (cond_true) begin
        resp_next.directive = DIR_COND_TRAP; // [RULE2] [RULE3]
      end else begin
        resp_next.directive = DIR_CONTINUE; // [RULE4]
      end
    end else if (val_fmt1 || val_fmt2) begin
      resp_next.length_words = LEN_BASE;
      areg_next = val_fmt2 ? cmd.ext_word[VAL_AREG_LSB +: 3] : 3'h0; // [RULE13]
      if (!ea_legal(ea_mode, ea_reg)) begin
        resp_next.directive = DIR_LINE_F; // [RULE14]
      end else if (!access_enable_field) begin
        resp_next.directive = DIR_ACCESS_LEVEL; // [RULE11]
      end else if (level_too_low) begin
        resp_next.directive = DIR_ACCESS_LEVEL; // [RULE10]
      end else begin
        resp_next.directive = DIR_CONTINUE; // [RULE10]
      end
    end else begin
      // Anything else reaching this decoder is not ours to run
      resp_next.directive = DIR_LINE_F;
      resp_next.length_words = LEN_BASE;
    end
  end

  // Answer register: one cycle after the command pulse
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      resp_valid <= 1'b0;
      resp <= RESPONSE_RESET;
      areg_select <= 3'h0;
    end else begin
      resp_valid <= cmd_valid;
      if (cmd_valid) begin
        resp <= resp_next; // [RULE8]
        areg_select <= areg_next;
      end
    end
  end

  // Validation level register, written by software only
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      validation_level_reg <= VAL_RESET;
    end else if (val_write) begin
      validation_level_reg <= val_write_data;
    end
  end

  // Status register loads only on a finished search, never from these instructions
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      translation_status_reg <= STATUS_RESET;
    end else if (search_done) begin // [RULE18]
      translation_status_reg.i <= search_result.no_valid_translation; // [RULE16]
      translation_status_reg.b <= search_result.fetch_bus_error ||
                                  (search_result.cache_only_test && search_result.cache_entry_bus_error); // [RULE17]
      translation_status_reg.l <= search_result.limit_exceeded;
      translation_status_reg.s <= search_result.supervisor_fault;
      translation_status_reg.a <= search_result.access_denied;
      translation_status_reg.w <= search_result.write_protected;
      translation_status_reg.g <= search_result.modified_page;
      translation_status_reg.c <= search_result.global_shared;
    end
  end

endmodule

// ---- host_cpu_model.sv ----
// Main processor model: issues decoder commands and stacks the return address of a taken trap.
// Assumes the bench raises issue just after a rising edge for one cycle per instruction.
`timescale 1ns/1ps
module host_cpu_model
  import tcpv_pkg::*;
#(
  parameter logic [31:0] PC_BASE = 32'h0000_1000
)
(
  input wire logic clk,
  input wire logic issue,
  input wire command_s issue_cmd,
  input wire logic issue_sup,
  input wire logic resp_valid,
  input wire response_s resp,
  output logic cmd_valid,
  output command_s cmd,
  output logic supervisor,
  output logic [31:0] stacked_pc
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    supervisor = 1'b0;
    stacked_pc = 32'h0000_0000;
  end
  // Launch on the falling edge; ea_addr is already the logical address itself
  always @(negedge clk) begin
    cmd_valid <= issue;
    cmd <= issue ? issue_cmd : ~cmd; // Idle words keep toggling, never a stale match
    supervisor <= issue_sup;
  end
  // Saved counter points past condition word and trailing words
  always @(posedge clk) begin
    if (resp_valid && resp.directive == DIR_COND_TRAP) begin
      stacked_pc <= PC_BASE + 32'({resp.length_words, 1'b0});
    end
  end
endmodule

// ---- trap_condition_pointer_validate_sva.sv ----
// Port checker for the trap-on-condition and pointer-validate decoder.
// Assumes commands only after the synchronised reset has ended.
`timescale 1ns/1ps
module tcpv_sva
  import tcpv_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire command_s cmd,
  input wire logic supervisor,
  input wire logic access_enable_field,
  input wire logic search_done,
  input wire search_s search_result,
  input wire logic resp_valid,
  input wire response_s resp,
  input wire status_s translation_status_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic trap, mode_ok;
  // Decode helpers, kept combinational so the properties stay short
  assign trap = cmd_valid && ((cmd.op_word & TRAP_OP_MASK) == TRAP_OP_MATCH);
  assign mode_ok = cmd.op_word[2:0] inside {OPMODE_ONE_WORD, OPMODE_TWO_WORDS, OPMODE_NO_WORDS};
  chk_resp_next: assert property (cmd_valid |=> resp_valid) else $error("no answer");
  chk_resp_single: assert property (!cmd_valid |=> !resp_valid) else $error("stray answer");
  chk_user_trap: assert property (trap && !supervisor |=> resp.directive == DIR_PRIVILEGE)
    else $error("user trap not refused");
  chk_bad_mode: assert property (trap && supervisor && !mode_ok |=> resp.directive == DIR_LINE_F)
    else $error("bad mode accepted");
  chk_two_trail: assert property (trap && cmd.op_word[2:0] == OPMODE_TWO_WORDS
    |=> resp.length_words == 3'h4) else $error("length wrong");
  chk_cond_eval: assert property (trap && supervisor && mode_ok
    && cmd.ext_word[15:4] == 12'h000
    |=> resp.directive == ($past(translation_status_reg[cmd.ext_word[3:1]] ^ cmd.ext_word[0]) ? DIR_COND_TRAP
    : DIR_CONTINUE)) else $error("condition wrong");
  chk_status_kept: assert property (!search_done |=> $stable(translation_status_reg))
    else $error("status changed");
  chk_invalid_flag: assert property (search_done
    |=> translation_status_reg.i == $past(search_result.no_valid_translation)) else $error("invalid flag wrong");
  chk_bus_flag: assert property (search_done |=> translation_status_reg.b
    == $past(search_result.fetch_bus_error | search_result.cache_only_test & search_result.cache_entry_bus_error))
    else $error("bus flag wrong");
  chk_val_off: assert property (cmd_valid && cmd.op_word == 16'hF010 && cmd.ext_word == VAL_FMT1_WORD
    && !access_enable_field |=> resp.directive == DIR_ACCESS_LEVEL) else $error("disabled validate passed");
  cov_trap: cover property (trap && supervisor);
  cov_search: cover property (search_done);
  cov_level: cover property (resp_valid && resp.directive == DIR_ACCESS_LEVEL);
endmodule
bind trap_condition_pointer_validate tcpv_sva tcpv_sva_i (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
  .supervisor(supervisor), .access_enable_field(access_enable_field), .search_done(search_done),
  .search_result(search_result), .resp_valid(resp_valid), .resp(resp), .translation_status_reg(translation_status_reg));

// ---- trap_condition_pointer_validate_bench.sv ----
// Self-checking bench: processor model in front, status and level inputs driven here.
// Assumes the package, processor model and checker are compiled first.
`timescale 1ns/1ps
module trap_condition_pointer_validate_bench
  import tcpv_pkg::*;
;
  logic clk = 0, rstn = 0, issue = 0, isup = 0, en = 1, val_write = 0, search_done = 0;
  logic [1:0] cnt = 2'h0;
  logic [31:0] val_data = 32'h0000_0000;
  command_s icmd = '0, cmd;
  search_s sres = '0;
  logic cmd_valid, supervisor, resp_valid;
  response_s resp;
  status_s st;
  logic [31:0] vreg, pc;
  logic [2:0] asel;
  int n_mismatch = 0, num_checks = 0;
  host_cpu_model host_cpu_model_i (.clk(clk), .issue(issue), .issue_cmd(icmd), .issue_sup(isup),
    .resp_valid(resp_valid), .resp(resp), .cmd_valid(cmd_valid), .cmd(cmd), .supervisor(supervisor),
    .stacked_pc(pc));
  trap_condition_pointer_validate trap_condition_pointer_validate_i (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd(cmd), .supervisor(supervisor), .access_enable_field(en), .access_level_count_field(cnt),
    .val_write(val_write), .val_write_data(val_data), .search_done(search_done), .search_result(sres),
    .resp_valid(resp_valid), .resp(resp), .translation_status_reg(st), .validation_level_reg(vreg),
    .areg_select(asel));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // One instruction through the processor model; answer judged in its single valid cycle
  task automatic run(input logic [15:0] op, input logic [15:0] ext, input logic [31:0] ea, input logic [31:0] ar,
                     input logic sup, input directive_e dir, input logic [2:0] len);
    int k;
    @(posedge clk);
    issue = 1'b1;
    icmd = '{op, ext, ea, ar};
    isup = sup;
    @(posedge clk);
    issue = 1'b0;
    // Answer looked at on falling edges only, never in the edge that launches it
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (resp_valid !== 1'b1 && k < 4);
    if (resp_valid !== 1'b1) begin
      n_mismatch++;
      close_out();
    end else begin
      check(resp.directive, dir, "directive");
      check(resp.length_words, len, "length");
    end
  endtask
  task automatic search(input search_s r, input logic [7:0] exp);
    @(negedge clk);
    search_done = 1'b1;
    sres = r;
    @(negedge clk);
    search_done = 1'b0;
    sres = ~r;
    @(negedge clk);
    check(st, exp, "status");
  endtask
  // Every condition code against flags i, l and b (cache-only bus error path)
  task automatic t_conditions();
    logic [7:0] pat = 8'h23;
    search(10'h2E0, pat);
    for (int c = 0; c < 16; c++) begin
      run(16'hF07C, 16'(c), 32'h0, 32'h0, 1'b1, (pat[c[3:1]] ^ c[0]) ? DIR_COND_TRAP : DIR_CONTINUE,
          3'h2);
    end
    check(st, pat, "status kept");
  endtask
  task automatic t_modes();
    run(16'hF07A, 16'h000A, 32'h0, 32'h0, 1'b1, DIR_COND_TRAP, 3'h3);
    run(16'hF07B, 16'h000A, 32'h0, 32'h0, 1'b1, DIR_COND_TRAP, 3'h4);
    @(negedge clk);
    check(pc, 32'h0000_1008, "stacked pc");
    run(16'hF07C, 16'h000B, 32'h0, 32'h0, 1'b1, DIR_CONTINUE, 3'h2);
    run(16'hF07C, 16'h0010, 32'h0, 32'h0, 1'b1, DIR_LINE_F, 3'h2);
    run(16'hF078, 16'h000A, 32'h0, 32'h0, 1'b1, DIR_LINE_F, 3'h2);
    run(16'hF07F, 16'h000A, 32'h0, 32'h0, 1'b1, DIR_LINE_F, 3'h2);
    run(16'hF07A, 16'h000A, 32'h0, 32'h0, 1'b0, DIR_PRIVILEGE, 3'h3);
    run(16'hF07C, 16'h000B, 32'h0, 32'h0, 1'b0, DIR_PRIVILEGE, 3'h2);
  endtask
  task automatic t_validate();
    logic [15:0] ops [11] = '{16'hF010, 16'hF028, 16'hF030, 16'hF038, 16'hF039, 16'hF000, 16'hF008, 16'hF018,
                              16'hF020, 16'hF03A, 16'hF03C};
    @(negedge clk);
    val_write = 1'b1;
    val_data = 32'h3000_0000;
    @(negedge clk);
    val_write = 1'b0;
    check(vreg, 32'h3000_0000, "level reg");
    cnt = 2'h3;
    run(16'hF010, 16'h2800, 32'h2000_0000, 32'h0, 1'b1, DIR_ACCESS_LEVEL, 3'h2);
    run(16'hF010, 16'h2800, 32'h3FFF_FFFF, 32'h0, 1'b1, DIR_CONTINUE, 3'h2);
    cnt = 2'h0;
    run(16'hF010, 16'h2800, 32'h0000_0000, 32'h0, 1'b0, DIR_CONTINUE, 3'h2);
    run(16'hF028, 16'h2C05, 32'h6000_0000, 32'h9000_0000, 1'b1, DIR_ACCESS_LEVEL, 3'h2);
    check(asel, 3'h5, "areg select");
    cnt = 2'h3;
    run(16'hF028, 16'h2C02, 32'h6000_0000, 32'h5FFF_FFFF, 1'b1, DIR_CONTINUE, 3'h2);
    for (int m = 0; m < 11; m++) begin
      run(ops[m], 16'h2800, 32'hF000_0000, 32'h0, 1'b1, m < 5 ? DIR_CONTINUE : DIR_LINE_F, 3'h2);
    end
    // Format one never names a processor register
    check(asel, 3'h0, "areg cleared");
    en = 1'b0;
    run(16'hF010, 16'h2800, 32'hF000_0000, 32'h0, 1'b1, DIR_ACCESS_LEVEL, 3'h2);
    en = 1'b1;
  endtask
  // Reset, then scenarios; the status reload ends with a fetch bus error only
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(st, 8'h00, "status reset");
    check(resp_valid, 1'b0, "answer reset");
    check(vreg, 32'h0000_0000, "level reset");
    check(asel, 3'h0, "areg reset");
    t_conditions();
    t_modes();
    t_validate();
    // Cache-only test without an errored entry must leave the bus-error flag clear
    search(10'h080, 8'h00);
    search(10'h100, 8'h01);
    close_out();
  end
endmodule
